// ---- bench/charger_status_control_regs_tb_top.sv ----
// Self-checking bench for the charger register bank
`timescale 1ns/1ps
module charger_status_control_regs_tb_top;
  // ***************************************************************
  // Signals
  // ***************************************************************
  localparam logic [3:0] PART_ID = 4'h9;  // Arbitrary value
  localparam int         DLY     = 1;     // Drive delay after the edge
  logic        ref_clk, rst, reg_wr, reg_rd, wd_exp;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, d, v;
  logic [4:0]  pins;         // Good, vlim, ilim, topoff, overvoltage
  logic        irq, restart, fault, cslow, wslow;
  logic [6:0]  cpct, wpct;
  logic [13:0] cthr, wthr;
  int          errors, check_count, n;
  csr_charger_regs #(.PART_CODE(PART_ID)) dut_u (.ref_clk(ref_clk),
    .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .input_source_good(pins[4]),
    .input_voltage_limit_active(pins[3]), .input_current_limit_active(pins[2]),
    .final_charge_timer_running(pins[1]), .input_overvoltage_flag(pins[0]),
    .watchdog_expired(wd_exp), .host_irq_pulse(irq),
    .safety_timer_restart(restart), .watchdog_fault(fault),
    .cool_band_charge_pct(cpct), .warm_band_charge_pct(wpct),
    .cool_band_slowdown_ok(cslow), .warm_band_slowdown_ok(wslow),
    .cool_edge_threshold_bp(cthr), .warm_edge_threshold_bp(wthr));
  csr_host_model host_u (.ref_clk(ref_clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  // Free running clock
  always #50 ref_clk = ~ref_clk;
  // ***************************************************************
  // Checking helpers
  // ***************************************************************
  task chk(input logic [13:0] seen, input logic [13:0] exp, input string m);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, m, seen,
               exp);
    end
  endtask
  task end_sim;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  function automatic logic [6:0] e_pct(input logic [1:0] c);
    logic [6:0] t [4] = '{7'h00, 7'h14, 7'h32, 7'h64};
    return t[c];
  endfunction
  function automatic logic [13:0] e_cool(input logic [1:0] c);
    logic [13:0] t [4] = '{14'h1ba3, 14'h1aa9, 14'h197d, 14'h1851};
    return t[c];
  endfunction
  function automatic logic [13:0] e_warm(input logic [1:0] c);
    logic [13:0] t [4] = '{14'h12d9, 14'h117b, 14'h0feb, 14'h0ebf};
    return t[c];
  endfunction
  task rchk(input logic [7:0] a, input logic [7:0] e);
    host_u.rd(a, d);
    chk(d, e, "register read");
  endtask
  task check_ctrl(input logic [7:0] c);
    chk(cpct, e_pct(c[7:6]), "cool pct");
    chk(wpct, e_pct(c[5:4]), "warm pct");
    chk(cslow, c[7:6] != 2'h3, "cool slowdown");
    chk(wslow, c[5:4] != 2'h3, "warm slowdown");
    chk(cthr, e_cool(c[3:2]), "cool edge");
    chk(wthr, e_warm(c[1:0]), "warm edge");
  endtask
  task set_pins(input logic [4:0] p);
    @(posedge ref_clk);
    #DLY pins = p;
  endtask
  // Waits a bounded time for a pulse, then counts its high cycles
  task wait_pulse(output int len);
    int k;
    len = 0;
    k = 0;
    while (irq !== 1'b1 && k < 20) begin
      @(posedge ref_clk);
      #DLY k++;
    end
    while (irq === 1'b1 && len < 3000) begin
      @(posedge ref_clk);
      #DLY len++;
    end
  endtask
  task irq_try(input logic [4:0] p, input logic exp);
    int len;
    set_pins(5'h00);
    repeat (4) @(posedge ref_clk);
    set_pins(p);
    wait_pulse(len);
    chk(14'(len), exp ? 14'(csr_pkg::IRQ_PULSE_CYC) : 14'h0000,
        "pulse");
  endtask
  // Hang guard
  initial begin
    repeat (100000) @(posedge ref_clk);
    errors++;
    end_sim;
  end
  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    pins = 5'h00;
    wd_exp = 1'b0;
    errors = 0;
    check_count = 0;
    void'($urandom(32'hf226));
    repeat (12) @(posedge ref_clk);
    #DLY rst = 1'b0;
    repeat (3) @(posedge ref_clk);
    #DLY chk(fault, 1'b1, "fault after reset");
    rchk(8'h0c, 8'h75);
    check_ctrl(8'h75);
    rchk(8'h0a, 8'h00);
    // Read-only part bits, writing zero to the reset bit, unmapped place
    host_u.wr(8'h0b, 8'h7f);
    rchk(8'h0b, {1'b0, PART_ID, 3'h4});
    host_u.wr(8'h0d, 8'hff);
    rchk(8'h0d, 8'h00);
    rchk(8'h0c, 8'h75);
    // Every code of every field first, then random settings
    for (int i = 0; i < 16; i++) begin
      v = (i < 4) ? 8'(i * 8'h55) : 8'($urandom);
      host_u.wr(8'h0c, v);
      rchk(8'h0c, v);
      check_ctrl(v);
    end
    // Status bits with both blocks set; status writes must not land
    host_u.wr(8'h0a, 8'hff);
    for (int i = 0; i < 8; i++) begin
      set_pins(5'($urandom));
      repeat (3) @(posedge ref_clk);
      rchk(8'h0a, {pins[4:2], 1'b0, pins[1:0], 2'h3});
      chk(irq, 1'b0, "blocked pulse");
    end
    // Each block setting against each limit entry
    for (int m = 0; m < 4; m++) begin
      set_pins(5'h00);
      host_u.wr(8'h0a, 8'(m));
      irq_try(5'h08, !m[1]);
      irq_try(5'h04, !m[0]);
    end
    // Entry during a pulse gives exactly one more pulse afterwards
    host_u.wr(8'h0a, 8'h00);
    irq_try(5'h08, 1'b1);
    set_pins(5'h00);
    repeat (4) @(posedge ref_clk);
    set_pins(5'h08);
    repeat (10) @(posedge ref_clk);
    set_pins(5'h0c);
    wait_pulse(n);
    wait_pulse(n);
    chk(14'(n), 14'(csr_pkg::IRQ_PULSE_CYC), "held pulse");
    // Register reset restores defaults except the threshold high bits and restarts the timer
    set_pins(5'h00);
    host_u.wr(8'h0a, 8'h03);
    host_u.wr(8'h0c, 8'hff);
    host_u.wr(8'h0b, 8'h80);
    n = 0;
    while (restart !== 1'b1 && n < 10) begin
      @(posedge ref_clk);
      #DLY n++;
    end
    chk(restart, 1'b1, "timer restart");
    rchk(8'h0b, {1'b0, PART_ID, 3'h4});
    rchk(8'h0c, 8'h7f);
    rchk(8'h0a, 8'h00);
    // Mid-run reset: settings and fault flag return to defaults
    host_u.wr(8'h0c, 8'haa);
    rst = 1'b1;
    repeat (2) @(posedge ref_clk);
    #DLY rst = 1'b0;
    chk(fault, 1'b1, "fault after second reset");
    rchk(8'h0c, 8'h75);
    // Watchdog expiry returns the band fields to defaults
    host_u.wr(8'h0c, 8'hff);
    repeat (2) @(posedge ref_clk);
    #DLY chk(fault, 1'b0, "fault cleared");
    set_pins(5'h00);
    wd_exp = 1'b1;
    repeat (5) @(posedge ref_clk);
    #DLY chk(fault, 1'b1, "watchdog fault");
    rchk(8'h0c, 8'h75);
    check_ctrl(8'h75);
    end_sim;
  end
endmodule // charger_status_control_regs_tb_top

// ---- bench/csr_charger_regs_monitor.sv ----
// Concurrent checks on the charger register bank ports
`timescale 1ns/1ps
module csr_charger_regs_monitor #(
  parameter logic [3:0] PART_CODE = 4'h5   // Arbitrary identity value
) (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        watchdog_expired,
  input wire logic        host_irq_pulse,
  input wire logic        safety_timer_restart,
  input wire logic        watchdog_fault,
  input wire logic [6:0]  cool_band_charge_pct,
  input wire logic [6:0]  warm_band_charge_pct,
  input wire logic        cool_band_slowdown_ok,
  input wire logic        warm_band_slowdown_ok,
  input wire logic [13:0] cool_edge_threshold_bp,
  input wire logic [13:0] warm_edge_threshold_bp
);
  // ***************************************************************
  // Helpers
  // ***************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic        rd_ctrl;      // Plain read of the band control register
  logic        rst_req;      // Host asks for a register reset
  logic [11:0] hi_cnt_reg;   // High cycles of the current pulse
  logic [11:0] hi_cnt_next;
  assign rd_ctrl = reg_rd && !reg_wr && reg_addr == 8'h0c;
  assign rst_req = reg_wr && reg_addr == 8'h0b && reg_wdata[7];
  // Percent share per scale code
  function automatic logic [6:0] pct(input logic [1:0] c);
    pct = (c == 2'h0) ? 7'h00 : (c == 2'h1) ? 7'h14 :
          (c == 2'h2) ? 7'h32 : 7'h64;
  endfunction
  // Edge ratios in hundredths of a percent
  function automatic logic [13:0] cool_r(input logic [1:0] c);
    cool_r = (c == 2'h0) ? 14'h1ba3 : (c == 2'h1) ? 14'h1aa9 :
             (c == 2'h2) ? 14'h197d : 14'h1851;
  endfunction
  function automatic logic [13:0] warm_r(input logic [1:0] c);
    warm_r = (c == 2'h0) ? 14'h12d9 : (c == 2'h1) ? 14'h117b :
             (c == 2'h2) ? 14'h0feb : 14'h0ebf;
  endfunction
  // Counter restarts whenever the pulse is low
  always_comb hi_cnt_next = host_irq_pulse ? hi_cnt_reg + 12'h001 : 12'h000;
  // Length counter register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hi_cnt_reg <= 12'h000;
    end else begin
      hi_cnt_reg <= hi_cnt_next;
    end
  end
  a_cool_scale: assert property (rd_ctrl |=>
    cool_band_charge_pct == pct(reg_rdata[7:6])) else $error("cool pct");
  a_warm_scale: assert property (rd_ctrl |=>
    warm_band_charge_pct == pct(reg_rdata[5:4])) else $error("warm pct");
  a_slow_full: assert property (rd_ctrl |=>
    cool_band_slowdown_ok == (reg_rdata[7:6] != 2'h3) &&
    warm_band_slowdown_ok == (reg_rdata[5:4] != 2'h3)) else $error("slowdown");
  a_cool_edge: assert property (rd_ctrl |=>
    cool_edge_threshold_bp == cool_r(reg_rdata[3:2])) else $error("cool edge");
  a_warm_edge: assert property (rd_ctrl |=>
    warm_edge_threshold_bp == warm_r(reg_rdata[1:0])) else $error("warm edge");
  a_part_code: assert property (reg_rd && reg_addr == 8'h0b |=>
    reg_rdata[6:0] == {PART_CODE, 3'h4}) else $error("part code");
  a_irq_len: assert property ($fell(host_irq_pulse) |->
    hi_cnt_reg == 12'(csr_pkg::IRQ_PULSE_CYC)) else $error("pulse length");
  a_irq_max_len: assert property (host_irq_pulse |->
    hi_cnt_reg < 12'(csr_pkg::IRQ_PULSE_CYC)) else $error("pulse too long");
  a_restart_cause: assert property (rst_req |->
    ##[1:3] safety_timer_restart) else $error("no timer restart");
  a_restart_one: assert property (safety_timer_restart |=>
    !safety_timer_restart) else $error("restart too long");
  a_fault_set: assert property ($rose(watchdog_expired) |->
    ##[1:4] watchdog_fault) else $error("fault not set");
  c_irq: cover property ($rose(host_irq_pulse));
  c_restart: cover property (safety_timer_restart);
  c_fault: cover property ($rose(watchdog_fault));
endmodule // csr_charger_regs_monitor

bind csr_charger_regs csr_charger_regs_monitor #(.PART_CODE(PART_CODE)) mon_u (
  .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .watchdog_expired(watchdog_expired), .host_irq_pulse(host_irq_pulse),
  .safety_timer_restart(safety_timer_restart),
  .watchdog_fault(watchdog_fault),
  .cool_band_charge_pct(cool_band_charge_pct),
  .warm_band_charge_pct(warm_band_charge_pct),
  .cool_band_slowdown_ok(cool_band_slowdown_ok),
  .warm_band_slowdown_ok(warm_band_slowdown_ok),
  .cool_edge_threshold_bp(cool_edge_threshold_bp),
  .warm_edge_threshold_bp(warm_edge_threshold_bp));

// ---- bench/csr_host_model.sv ----
// Host processor model on the register strobe port
`timescale 1ns/1ps
module csr_host_model (
  input  wire logic       ref_clk,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  // ***************************************************************
  // Bus cycles
  // ***************************************************************
  localparam int DLY = 1;  // Drive delay after the edge
  // Idle bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // One write; released lines are inverted so stale values never help
  task automatic wr(input logic [7:0] a, input logic [7:0] dat);
    @(posedge ref_clk);
    #DLY reg_addr = a;
    reg_wdata = dat;
    reg_wr = 1'b1;
    @(posedge ref_clk);
    #DLY reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~dat;
  endtask
  // One read; data is taken one edge after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] dat);
    @(posedge ref_clk);
    #DLY reg_addr = a;
    reg_rd = 1'b1;
    @(posedge ref_clk);
    #DLY reg_rd = 1'b0;
    reg_addr = ~a;
    @(posedge ref_clk);
    #DLY dat = reg_rdata;
  endtask
endmodule // csr_host_model

// ---- rtl/csr_charger_regs.sv ----
// Charger status two, part information and temperature band registers
`timescale 1ns/1ps
module csr_charger_regs #(
  parameter logic [3:0] PART_CODE = 4'h5   // Arbitrary identity value
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Register access port, one transaction per strobe
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Condition pins from the analog side, asynchronous
  input  wire logic        input_source_good,
  input  wire logic        input_voltage_limit_active,
  input  wire logic        input_current_limit_active,
  input  wire logic        final_charge_timer_running,
  input  wire logic        input_overvoltage_flag,
  input  wire logic        watchdog_expired,
  // Outputs to host and charge control
  output logic             host_irq_pulse,
  output logic             safety_timer_restart,
  output logic             watchdog_fault,
  output logic      [6:0]  cool_band_charge_pct,
  output logic      [6:0]  warm_band_charge_pct,
  output logic             cool_band_slowdown_ok,
  output logic             warm_band_slowdown_ok,
  output logic      [13:0] cool_edge_threshold_bp,
  output logic      [13:0] warm_edge_threshold_bp
);

  // ***************************************************************
  // Pin synchronisers
  // ***************************************************************
  logic [5:0] pins_in;      // Raw pins gathered
  logic [5:0] sync1_reg;    // First stage, read only by second
  logic [5:0] sync2_reg;    // Safe to use

  assign pins_in = {watchdog_expired, input_source_good,
                    input_voltage_limit_active, input_current_limit_active,
                    final_charge_timer_running, input_overvoltage_flag};

  // Two flops per pin; the analog flags settle at their own pace
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= 6'h00;
      sync2_reg <= 6'h00;
    end else begin
      sync1_reg <= pins_in;
      sync2_reg <= sync1_reg;
    end
  end

  logic wd_s;               // Synchronised watchdog expiry level
  logic good_s;
  logic vlim_s;
  logic ilim_s;
  logic topoff_s;
  logic ovp_s;
  assign {wd_s, good_s, vlim_s, ilim_s, topoff_s, ovp_s} = sync2_reg;

  // ***************************************************************
  // Register state
  // ***************************************************************
  logic       vblock_reg, vblock_next;     // Voltage limit irq block
  logic       iblock_reg, iblock_next;     // Current limit irq block
  logic [7:0] tctl_reg, tctl_next;         // Temperature band control
  logic       rreset_reg, rreset_next;     // Register reset in progress
  logic       restart_reg, restart_next;   // Safety timer restart pulse
  logic       wdf_reg, wdf_next;           // Watchdog fault flag
  logic       wd_prev_reg, wd_prev_next;   // For expiry edge
  logic       vlim_prev_reg, vlim_prev_next;
  logic       ilim_prev_reg, ilim_prev_next;
  logic       vpend_reg, vpend_next;       // Unserved voltage entry
  logic       ipend_reg, ipend_next;       // Unserved current entry
  logic [7:0] rdata_reg, rdata_next;       // Read data

  logic [7:0] status_val;                  // Status two as read
  logic [7:0] part_val;                    // Part information as read
  logic       wr_stat;                     // Write decode strobes
  logic       wr_part;
  logic       wr_tctl;
  logic       wd_rise;                     // Watchdog expiry event
  logic       vlim_rise;                   // Regulation entries
  logic       ilim_rise;

  csr_irq_if irq_bus ();                   // To pulse maker

  // Read views; reserved bit 4 reads zero
  assign status_val = {good_s, vlim_s, ilim_s, 1'b0,
                       topoff_s, ovp_s, vblock_reg, iblock_reg};
  assign part_val   = {rreset_reg, PART_CODE,
                       csr_pkg::PART_RSVD_VAL};

  assign wr_stat   = reg_wr && (reg_addr == csr_pkg::ADDR_STATUS_TWO);
  assign wr_part   = reg_wr && (reg_addr == csr_pkg::ADDR_PART_INFO);
  assign wr_tctl   = reg_wr && (reg_addr == csr_pkg::ADDR_TEMP_CTRL);
  assign wd_rise   = wd_s && !wd_prev_reg;
  assign vlim_rise = vlim_s && !vlim_prev_reg;
  assign ilim_rise = ilim_s && !ilim_prev_reg;

  // One request covers every entry waiting when the maker is idle
  assign irq_bus.req = vpend_reg || ipend_reg;

  // Next values for the whole register bank
  always_comb begin
    vblock_next    = vblock_reg;
    iblock_next    = iblock_reg;
    tctl_next      = tctl_reg;
    rreset_next    = rreset_reg;
    restart_next   = 1'b0;
    wdf_next       = wdf_reg;
    wd_prev_next   = wd_s;
    vlim_prev_next = vlim_s;
    ilim_prev_next = ilim_s;
    vpend_next     = vpend_reg;
    ipend_next     = ipend_reg;
    rdata_next     = rdata_reg;

    // Host writes; read-only bits and part code are dropped
    if (wr_stat) begin
      vblock_next = reg_wdata[csr_pkg::BIT_VLIM_BLOCK];
      iblock_next = reg_wdata[csr_pkg::BIT_ILIM_BLOCK];
    end
    if (wr_tctl) begin
      tctl_next = reg_wdata;
    end
    // Writing zero to the reset bit leaves settings alone
    if (wr_part && reg_wdata[csr_pkg::BIT_REG_RESET]) begin
      rreset_next = 1'b1;
    end
    // Any host write returns the device to host mode
    if (reg_wr) begin
      wdf_next = 1'b0;
    end

    // Register reset applies one cycle after the request, then clears
    if (rreset_reg) begin
      vblock_next  = csr_pkg::IRQ_BLOCK_RST;
      iblock_next  = csr_pkg::IRQ_BLOCK_RST;
      tctl_next    = (tctl_reg & csr_pkg::TEMP_CTRL_KEEP) |
                     (csr_pkg::TEMP_CTRL_RST & ~csr_pkg::TEMP_CTRL_KEEP);
      restart_next = 1'b1;
      rreset_next  = 1'b0;
    end

    // Watchdog expiry wins over a same-cycle host write
    if (wd_rise) begin
      tctl_next = csr_pkg::TEMP_CTRL_RST;
      wdf_next  = 1'b1;
    end

    // Entries: served request clears, new entry in same cycle wins
    if (irq_bus.ready && irq_bus.req) begin
      vpend_next = 1'b0;
      ipend_next = 1'b0;
    end
    if (vlim_rise && !vblock_reg) begin
      vpend_next = 1'b1;
    end
    if (ilim_rise && !iblock_reg) begin
      ipend_next = 1'b1;
    end
    // Blocking an entry also drops one still waiting
    if (vblock_reg) begin
      vpend_next = 1'b0;
    end
    if (iblock_reg) begin
      ipend_next = 1'b0;
    end

    // Read data; unmapped offsets answer zero
    if (reg_rd) begin
      case (reg_addr)
        csr_pkg::ADDR_STATUS_TWO: rdata_next = status_val;
        csr_pkg::ADDR_PART_INFO:  rdata_next = part_val;
        csr_pkg::ADDR_TEMP_CTRL:  rdata_next = tctl_reg;
        default:                  rdata_next = 8'h00;
      endcase
    end
  end

  // Registers of the bank
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      vblock_reg    <= csr_pkg::IRQ_BLOCK_RST;
      iblock_reg    <= csr_pkg::IRQ_BLOCK_RST;
      tctl_reg      <= csr_pkg::TEMP_CTRL_RST;
      rreset_reg    <= 1'b0;
      restart_reg   <= 1'b0;
      wdf_reg       <= csr_pkg::WD_FAULT_RST;
      wd_prev_reg   <= 1'b0;
      vlim_prev_reg <= 1'b0;
      ilim_prev_reg <= 1'b0;
      vpend_reg     <= 1'b0;
      ipend_reg     <= 1'b0;
      rdata_reg     <= 8'h00;
    end else begin
      vblock_reg    <= vblock_next;
      iblock_reg    <= iblock_next;
      tctl_reg      <= tctl_next;
      rreset_reg    <= rreset_next;
      restart_reg   <= restart_next;
      wdf_reg       <= wdf_next;
      wd_prev_reg   <= wd_prev_next;
      vlim_prev_reg <= vlim_prev_next;
      ilim_prev_reg <= ilim_prev_next;
      vpend_reg     <= vpend_next;
      ipend_reg     <= ipend_next;
      rdata_reg     <= rdata_next;
    end
  end

  // ***************************************************************
  // Interrupt pulse maker
  // ***************************************************************
  csr_irq_pulse u_irq_pulse (
    .ref_clk (ref_clk),
    .rst     (rst),
    .irq     (irq_bus.gen)
  );

  // ***************************************************************
  // Outputs, all derived from flops
  // ***************************************************************
  logic [1:0] cool_code;   // Band fields
  logic [1:0] warm_code;
  assign cool_code = tctl_reg[csr_pkg::COOL_SCALE_LSB +: 2];
  assign warm_code = tctl_reg[csr_pkg::WARM_SCALE_LSB +: 2];

  assign reg_rdata              = rdata_reg;
  assign host_irq_pulse         = irq_bus.pulse;
  assign safety_timer_restart   = restart_reg;
  assign watchdog_fault         = wdf_reg;
  assign cool_band_charge_pct   = csr_pkg::scale_pct(cool_code);
  assign warm_band_charge_pct   = csr_pkg::scale_pct(warm_code);
  // Full scale keeps the safety timer at normal speed in that band
  assign cool_band_slowdown_ok  = (cool_code != csr_pkg::SCALE_FULL);
  assign warm_band_slowdown_ok  = (warm_code != csr_pkg::SCALE_FULL);
  assign cool_edge_threshold_bp = csr_pkg::cool_edge_bp(
           tctl_reg[csr_pkg::COOL_EDGE_LSB +: 2]);
  assign warm_edge_threshold_bp = csr_pkg::warm_edge_bp(
           tctl_reg[csr_pkg::WARM_EDGE_LSB +: 2]);

endmodule // csr_charger_regs

// ---- rtl/csr_irq_if.sv ----
// Handshake between the register bank and the interrupt pulse maker
`timescale 1ns/1ps
interface csr_irq_if;
  logic req;     // Bank has an unmasked regulation entry waiting
  logic ready;   // Pulse maker idle, takes req this cycle
  logic pulse;   // Interrupt pulse level to the host

  modport src (output req, input ready, input pulse);
  modport gen (input req, output ready, output pulse);
endinterface

// ---- rtl/csr_irq_pulse.sv ----
// Fixed-length interrupt pulse maker
`timescale 1ns/1ps
module csr_irq_pulse (
  input  wire logic ref_clk,
  input  wire logic rst,
  csr_irq_if.gen    irq
);

  // ***************************************************************
  // State
  // ***************************************************************
  typedef enum logic {CSR_IDLE, CSR_PULSE} csr_pulse_e;

  csr_pulse_e                  state_reg;   // Current phase
  csr_pulse_e                  state_next;
  logic [csr_pkg::IRQ_CNT_W-1:0] cnt_reg;   // Cycles left in pulse
  logic [csr_pkg::IRQ_CNT_W-1:0] cnt_next;
  logic                        pulse_reg;   // Registered pulse output
  logic                        pulse_next;

  // Ready only while idle, so a new entry never stretches a pulse
  assign irq.ready = (state_reg == CSR_IDLE);
  assign irq.pulse = pulse_reg;

  // Next-state: one request gives exactly one fixed pulse
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    pulse_next = pulse_reg;
    case (state_reg)
      CSR_IDLE: begin
        if (irq.req) begin
          state_next = CSR_PULSE;
          cnt_next   = csr_pkg::IRQ_CNT_W'(csr_pkg::IRQ_PULSE_CYC - 1);
          pulse_next = 1'b1;
        end
      end
      CSR_PULSE: begin
        if (cnt_reg == '0) begin
          state_next = CSR_IDLE;
          pulse_next = 1'b0;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      default: begin
        state_next = CSR_IDLE;
        cnt_next   = '0;
        pulse_next = 1'b0;
      end
    endcase
  end

  // Registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= CSR_IDLE;
      cnt_reg   <= '0;
      pulse_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      pulse_reg <= pulse_next;
    end
  end

endmodule // csr_irq_pulse

// ---- rtl/csr_pkg.sv ----
// Shared constants, encodings and helpers for the charger register bank
package csr_pkg;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int CLK_PERIOD_NS  = 100;      // Ref clock period, 10 MHz
  localparam int IRQ_PULSE_NS   = 256000;   // Host interrupt pulse length
  // Fixed pulse length, rounded down, never below one cycle
  localparam int IRQ_PULSE_CYC  = (IRQ_PULSE_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                  (IRQ_PULSE_NS / CLK_PERIOD_NS);
  localparam int IRQ_CNT_W      = 12;       // Holds IRQ_PULSE_CYC

  // ***************************************************************
  // Register offsets
  // ***************************************************************
  localparam logic [7:0] ADDR_STATUS_TWO = 8'h0a;
  localparam logic [7:0] ADDR_PART_INFO  = 8'h0b;
  localparam logic [7:0] ADDR_TEMP_CTRL  = 8'h0c;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int BIT_SRC_GOOD    = 7;       // Status two fields
  localparam int BIT_VLIM_ACT    = 6;
  localparam int BIT_ILIM_ACT    = 5;
  localparam int BIT_TOPOFF_RUN  = 3;
  localparam int BIT_OVERVOLT    = 2;
  localparam int BIT_VLIM_BLOCK  = 1;
  localparam int BIT_ILIM_BLOCK  = 0;
  localparam int BIT_REG_RESET   = 7;       // Part information
  localparam int COOL_SCALE_LSB  = 6;       // Temperature control
  localparam int WARM_SCALE_LSB  = 4;
  localparam int COOL_EDGE_LSB   = 2;
  localparam int WARM_EDGE_LSB   = 0;

  // ***************************************************************
  // Reset values
  // ***************************************************************
  localparam logic [7:0] TEMP_CTRL_RST   = 8'h75;
  // Bits that a register reset does not touch (threshold high bits)
  localparam logic [7:0] TEMP_CTRL_KEEP  = 8'h0a;
  localparam logic       IRQ_BLOCK_RST   = 1'b0;
  localparam logic [2:0] PART_RSVD_VAL   = 3'h4;
  localparam logic       WD_FAULT_RST    = 1'b1;

  // ***************************************************************
  // Encodings
  // ***************************************************************
  localparam logic [1:0] SCALE_FULL      = 2'h3;

  // Charge current share in percent for a band scale code
  function automatic logic [6:0] scale_pct(input logic [1:0] code);
    case (code)
      2'h0:    scale_pct = 7'h00;           // No charge
      2'h1:    scale_pct = 7'h14;           // 20 %
      2'h2:    scale_pct = 7'h32;           // 50 %
      default: scale_pct = 7'h64;           // 100 %
    endcase
  endfunction

  // Cool edge ratio in hundredths of a percent
  function automatic logic [13:0] cool_edge_bp(input logic [1:0] code);
    case (code)
      2'h0:    cool_edge_bp = 14'h1ba3;
      2'h1:    cool_edge_bp = 14'h1aa9;
      2'h2:    cool_edge_bp = 14'h197d;
      default: cool_edge_bp = 14'h1851;
    endcase
  endfunction

  // Warm edge ratio in hundredths of a percent
  function automatic logic [13:0] warm_edge_bp(input logic [1:0] code);
    case (code)
      2'h0:    warm_edge_bp = 14'h12d9;
      2'h1:    warm_edge_bp = 14'h117b;
      2'h2:    warm_edge_bp = 14'h0feb;
      default: warm_edge_bp = 14'h0ebf;
    endcase
  endfunction

endpackage
